// file: logic/ucg_cfg.svh
`ifndef UCG_CFG_SVH
`define UCG_CFG_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define UCG_OFS_CTRL    4'h0
`define UCG_OFS_BAUD    4'h4
`define UCG_OFS_STATUS  4'h8
`define UCG_OFS_XCKDIV  4'hC
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UCG_CTRL_START  0
`define UCG_CTRL_ONEW   1
`define UCG_CTRL_MODE_L 2
`define UCG_CTRL_MODE_H 4
`define UCG_CTRL_INV    5
`define UCG_CTRL_PHASE  6
`define UCG_CTRL_ORDER  7
`define UCG_CTRL_OPEN_DRAIN_ENABLE   8
`define UCG_CTRL_TXEN   9
`define UCG_CTRL_RXEN   10
`define UCG_CTRL_W      11
// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define UCG_ST_BUSY     0
`define UCG_ST_DONE     1
`define UCG_ST_ERRDIV   2
`define UCG_ST_ERRFRAC  3
`define UCG_ST_ERRACT   4
`define UCG_ST_ACTIVE   5
`define UCG_ST_XCKIN    6
// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define UCG_BAUD_RST    16'h0040
`define UCG_XCKDIV_RST  16'h0004
`define UCG_DIV_MIN     16'h0040
`define UCG_XCK_HALF_MIN 16'h0003
`define UCG_STEP_CYC    3'h4
`endif

// file: logic/ucg_pkg.sv
package ucg_pkg;
  typedef enum logic [2:0] {
    UCG_ASYNC, UCG_ASYNC_2X, UCG_SYNC_MASTER, UCG_SYNC_SLAVE, UCG_SPI_MASTER
  } ucg_mode_t;
  typedef enum logic [2:0] {
    S_IDLE, S_PINVAL, S_OPEN_DRAIN_ENABLE, S_PINDIR, S_FORMAT, S_MODE, S_ENABLE
  } ucg_state_t;
  // Settings applied to the device, in its own terms
  typedef struct packed {
    logic [15:0] divisor;
    ucg_mode_t   mode;
    logic        double_speed_setting;
    logic        pin_invert_enable;
    logic        spi_clock_phase;
    logic        spi_bit_order;
    logic        open_drain_enable;
    logic        tx_en;
    logic        rx_en;
  } ucg_dev_cfg_t;
  // Port pin value and direction for data and transfer clock pins
  typedef struct packed {
    logic txd_out;
    logic txd_dir;
    logic xck_out;
    logic xck_dir;
  } ucg_pins_t;
endpackage : ucg_pkg

// file: logic/ucg_host.sv
// Notes on behaviour
// RL1 - Five clocking modes, internal or external clock
// RL2 - Async divisor: 10 integer, 6 fraction bits
// RL3 - Fraction bits shift receive sampling point
// RL4 - Never program async divisor below 64
// RL5 - Sync modes: integer part only, fraction zero
// RL6 - Bit rate formulas; sync at most half clock
// RL7 - Sixteen samples normal, eight double speed
// RL8 - Double speed via receiver speed select field
// RL9 - Double speed doubles rate, halves samples
// RL10 - External transfer clock below quarter clock
// RL11 - Each clock phase sampled at least twice
// RL12 - Clock pin output master, input slave
// RL13 - Sample on edge opposite data change
// RL14 - Invert selects change and sample edges
// RL15 - SPI master uses synchronous master divider
// RL16 - SPI mode from inversion and phase
// RL17 - No phase or inversion change mid-transfer
// RL18 - Full-duplex init order: pins, divisor, mode, enable
// RL19 - One-wire init: open drain before direction
// RL20 - No reprogramming while transmission in progress
// RL21 - Keep interrupts off during initialisation
// RL22 - Non-SPI frames: start, data, parity, stop
// RL23 - SPI frames eight bits, selectable order
// RL24 - Fraction accumulated, period stretched on overflow
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ucg_cfg.svh"
module ucg_host
  import ucg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output ucg_dev_cfg_t     dev_cfg,
  output ucg_pins_t        dev_pins,
  output logic             dev_irq_en,
  input  wire logic        dev_active,
  input  wire logic        xck_i,
  output logic             xck_o,
  output logic             xck_oe_n
);
  localparam int SEQ_MAX = 40;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic act_m_r, act_s_r, xck_m_r, xck_s_r;
  // Both device pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      act_m_r <= 1'b0;
      act_s_r <= 1'b0;
      xck_m_r <= 1'b0;
      xck_s_r <= 1'b0;
    end else begin
      act_m_r <= dev_active;
      act_s_r <= act_m_r;
      xck_m_r <= xck_i;
      xck_s_r <= xck_m_r;
    end
  end
  // ----------------------------------------------------------------
  // Bus slave and register file
  // ----------------------------------------------------------------
  logic                 ack_r, ack_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic [`UCG_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0]          baud_r, baud_nxt, xdiv_r, xdiv_nxt;
  logic [4:2]           flag_r, flag_nxt;
  logic                 done_flag_r, done_flag_nxt, seq_end;
  logic                 wr_ok, go_w, go_ok, bad_div, bad_frac, sync_md;
  ucg_mode_t            req_mode;
  ucg_state_t           state_r, state_nxt;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  // One wait cycle per access; start checks use the value being written
  always_comb begin
    ack_nxt   = (avs_read | avs_write) & ~ack_r;
    wr_ok     = avs_write & ack_r;
    ctrl_nxt  = ctrl_r;
    baud_nxt  = baud_r;
    xdiv_nxt  = xdiv_r;
    rdata_nxt = rdata_r;
    if (wr_ok && avs_address == `UCG_OFS_CTRL) begin
      ctrl_nxt = avs_writedata[`UCG_CTRL_W-1:0];
    end
    if (wr_ok && avs_address == `UCG_OFS_BAUD) begin
      baud_nxt = avs_writedata[15:0];
    end
    if (wr_ok && avs_address == `UCG_OFS_XCKDIV) begin
      xdiv_nxt = avs_writedata[15:0];
    end
    case (ctrl_nxt[`UCG_CTRL_MODE_H:`UCG_CTRL_MODE_L])
      3'h1:    req_mode = UCG_ASYNC_2X;
      3'h2:    req_mode = UCG_SYNC_MASTER;
      3'h3:    req_mode = UCG_SYNC_SLAVE;
      3'h4:    req_mode = UCG_SPI_MASTER;
      default: req_mode = UCG_ASYNC;
    endcase
    sync_md  = (req_mode != UCG_ASYNC) && (req_mode != UCG_ASYNC_2X);
    bad_div  = !sync_md && (baud_nxt < `UCG_DIV_MIN); // RL4
    bad_frac = sync_md && (baud_nxt[5:0] != 6'h00); // RL5
    go_w     = wr_ok && avs_address == `UCG_OFS_CTRL
               && avs_writedata[`UCG_CTRL_START] && state_r == S_IDLE;
    go_ok    = go_w && !bad_div && !bad_frac && !act_s_r; // RL20
    // Sticky errors and done: a new event beats a clear in the same cycle
    flag_nxt = flag_r;
    if (wr_ok && avs_address == `UCG_OFS_STATUS) begin
      flag_nxt = flag_r & ~avs_writedata[`UCG_ST_ERRACT:`UCG_ST_ERRDIV];
    end
    flag_nxt[`UCG_ST_ERRDIV]  = flag_nxt[`UCG_ST_ERRDIV] | (go_w & bad_div);
    flag_nxt[`UCG_ST_ERRFRAC] = flag_nxt[`UCG_ST_ERRFRAC] | (go_w & bad_frac);
    flag_nxt[`UCG_ST_ERRACT]  = flag_nxt[`UCG_ST_ERRACT] | (go_w & act_s_r); // RL17
    if (avs_read && !ack_r) begin
      case (avs_address)
        `UCG_OFS_CTRL:   rdata_nxt = {21'h00_0000, ctrl_r};
        `UCG_OFS_BAUD:   rdata_nxt = {16'h0000, baud_r};
        `UCG_OFS_XCKDIV: rdata_nxt = {16'h0000, xdiv_r};
        `UCG_OFS_STATUS: rdata_nxt = {25'h000_0000, xck_s_r, act_s_r,
                                      flag_r, done_flag_r, state_r != S_IDLE};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  // Done is kept apart from the errors: the sequencer sets it
  always_comb begin
    done_flag_nxt = done_flag_r;
    if (wr_ok && avs_address == `UCG_OFS_STATUS && avs_writedata[`UCG_ST_DONE]) begin
      done_flag_nxt = 1'b0;
    end
    if (seq_end) begin
      done_flag_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_r       <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      ctrl_r      <= 11'h000;
      baud_r      <= `UCG_BAUD_RST;
      xdiv_r      <= `UCG_XCKDIV_RST;
      flag_r      <= 3'h0;
      done_flag_r <= 1'b0;
    end else begin
      ack_r       <= ack_nxt;
      rdata_r     <= rdata_nxt;
      ctrl_r      <= {ctrl_nxt[`UCG_CTRL_W-1:1], 1'b0};
      baud_r      <= baud_nxt;
      xdiv_r      <= xdiv_nxt;
      flag_r      <= flag_nxt;
      done_flag_r <= done_flag_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Initialisation sequencer
  // ----------------------------------------------------------------
  logic [2:0]   cnt_r, cnt_nxt;
  ucg_dev_cfg_t cfg_r, cfg_nxt, req_r, req_nxt;
  ucg_pins_t    pins_r, pins_nxt;
  logic         irq_r, irq_nxt, onew_r, onew_nxt, step_done;
  assign dev_cfg    = cfg_r;
  assign dev_pins   = pins_r;
  assign dev_irq_en = irq_r;
  // Each step is held a few cycles so the device sees them in order
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 3'h1;
    cfg_nxt   = cfg_r;
    pins_nxt  = pins_r;
    irq_nxt   = irq_r;
    req_nxt   = req_r;
    onew_nxt  = onew_r;
    step_done = (cnt_r == `UCG_STEP_CYC - 3'h1);
    seq_end   = 1'b0;
    case (state_r)
      S_IDLE: begin
        cnt_nxt = 3'h0;
        if (go_ok) begin
          state_nxt = S_PINVAL;
          onew_nxt  = ctrl_nxt[`UCG_CTRL_ONEW];
          req_nxt   = '{divisor: baud_nxt, mode: req_mode,
                        double_speed_setting: req_mode == UCG_ASYNC_2X,
                        pin_invert_enable: ctrl_nxt[`UCG_CTRL_INV],
                        spi_clock_phase: ctrl_nxt[`UCG_CTRL_PHASE],
                        spi_bit_order: ctrl_nxt[`UCG_CTRL_ORDER],
                        open_drain_enable: ctrl_nxt[`UCG_CTRL_OPEN_DRAIN_ENABLE],
                        tx_en: ctrl_nxt[`UCG_CTRL_TXEN],
                        rx_en: ctrl_nxt[`UCG_CTRL_RXEN]};
          irq_nxt   = 1'b0; // RL21
          cfg_nxt.tx_en = 1'b0;
          cfg_nxt.rx_en = 1'b0;
        end
      end
      S_PINVAL: begin
        pins_nxt.txd_out = 1'b1; // RL18
        pins_nxt.xck_out = 1'b0;
        if (step_done) begin
          state_nxt = onew_r ? S_OPEN_DRAIN_ENABLE : S_PINDIR;
          cnt_nxt   = 3'h0;
        end
      end
      S_OPEN_DRAIN_ENABLE: begin
        cfg_nxt.open_drain_enable = req_r.open_drain_enable; // RL19
        if (step_done) begin
          state_nxt = S_PINDIR;
          cnt_nxt   = 3'h0;
        end
      end
      S_PINDIR: begin
        pins_nxt.txd_dir = 1'b1; // RL18
        // Device clock pin is an output only while the device masters it
        pins_nxt.xck_dir = (req_r.mode == UCG_SYNC_MASTER)
                           || (req_r.mode == UCG_SPI_MASTER); // RL12
        if (step_done) begin
          state_nxt = S_FORMAT;
          cnt_nxt   = 3'h0;
        end
      end
      S_FORMAT: begin
        cfg_nxt.divisor       = req_r.divisor; // RL4 RL5
        cfg_nxt.spi_bit_order = req_r.spi_bit_order;
        if (step_done) begin
          state_nxt = S_MODE;
          cnt_nxt   = 3'h0;
        end
      end
      S_MODE: begin
        cfg_nxt.mode                 = req_r.mode;
        cfg_nxt.double_speed_setting = req_r.double_speed_setting;
        cfg_nxt.pin_invert_enable    = req_r.pin_invert_enable;
        cfg_nxt.spi_clock_phase      = req_r.spi_clock_phase;
        if (step_done) begin
          state_nxt = S_ENABLE;
          cnt_nxt   = 3'h0;
        end
      end
      S_ENABLE: begin
        cfg_nxt.tx_en = req_r.tx_en; // RL18
        cfg_nxt.rx_en = req_r.rx_en;
        if (step_done) begin
          state_nxt = S_IDLE;
          cnt_nxt   = 3'h0;
          irq_nxt   = 1'b1; // RL21
          seq_end   = 1'b1;
        end
      end
      default: begin
        state_nxt = S_IDLE;
        cnt_nxt   = 3'h0;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      cnt_r   <= 3'h0;
      cfg_r   <= '{divisor: `UCG_BAUD_RST, mode: UCG_ASYNC, default: 1'b0};
      req_r   <= '{divisor: `UCG_BAUD_RST, mode: UCG_ASYNC, default: 1'b0};
      pins_r  <= 4'h0;
      irq_r   <= 1'b1;
      onew_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cfg_r   <= cfg_nxt;
      req_r   <= req_nxt;
      pins_r  <= pins_nxt;
      irq_r   <= irq_nxt;
      onew_r  <= onew_nxt;
    end
  end
  // ----------------------------------------------------------------
  // External transfer clock for the device in slave mode
  // ----------------------------------------------------------------
  logic [15:0] xc_r, xc_nxt, half;
  logic        xo_r, xo_nxt, oen_r, oen_nxt;
  assign xck_o    = xo_r;
  assign xck_oe_n = oen_r;
  // Half period clamped so each phase spans at least three of our clocks,
  // which keeps the rate under a quarter of a like device clock
  always_comb begin
    half    = (xdiv_r < `UCG_XCK_HALF_MIN) ? `UCG_XCK_HALF_MIN : xdiv_r; // RL10 RL11
    oen_nxt = !(cfg_r.mode == UCG_SYNC_SLAVE); // RL12
    xc_nxt  = 16'h0000;
    xo_nxt  = 1'b0;
    if (!oen_r) begin
      xc_nxt = xc_r + 16'h0001;
      xo_nxt = xo_r;
      if (xc_r >= half - 16'h0001) begin
        xc_nxt = 16'h0000;
        xo_nxt = !xo_r;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      xc_r  <= 16'h0000;
      xo_r  <= 1'b0;
      oen_r <= 1'b1;
    end else begin
      xc_r  <= xc_nxt;
      xo_r  <= xo_nxt;
      oen_r <= oen_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_go;
    go_ok;
  endsequence
  sequence seq_enabled;
    state_r == S_ENABLE;
  endsequence
  AST_DIV_MIN: assert property (@(posedge clk_sys) disable iff (!resetn) // RL4
    (state_r == S_MODE && (req_r.mode == UCG_ASYNC || req_r.mode == UCG_ASYNC_2X))
      |-> cfg_r.divisor >= `UCG_DIV_MIN)
    else $error("Async divisor below minimum reached device");
  AST_FRAC_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn) // RL5
    (state_r == S_MODE && (req_r.mode == UCG_SYNC_MASTER || req_r.mode == UCG_SYNC_SLAVE
      || req_r.mode == UCG_SPI_MASTER)) |-> cfg_r.divisor[5:0] == 6'h00)
    else $error("Sync divisor has nonzero fraction");
  AST_XCK_PHASE: assert property (@(posedge clk_sys) disable iff (!resetn) // RL11
    (!oen_r && $changed(xo_r) && !$past(oen_r)) |-> $past(xc_r) >= 16'h0002)
    else $error("Transfer clock phase too short");
  AST_XCK_RATE: assert property (@(posedge clk_sys) disable iff (!resetn) // RL10
    $rose(xo_r) |=> (xo_r || oen_r) [*2])
    else $error("Transfer clock faster than allowed");
  AST_XCK_DIR: assert property (@(posedge clk_sys) disable iff (!resetn) // RL12
    $past(cfg_r.mode) == UCG_SYNC_MASTER && cfg_r.mode == UCG_SYNC_MASTER |-> xck_oe_n)
    else $error("Host drives clock while device is master");
  AST_HOLD_ACTIVE: assert property (@(posedge clk_sys) disable iff (!resetn) // RL17 RL20
    (state_r == S_IDLE && act_s_r) |=> $stable(cfg_r.spi_clock_phase)
      && $stable(cfg_r.pin_invert_enable) && $stable(cfg_r.divisor))
    else $error("Settings changed during transfer");
  AST_ORDER: assert property (@(posedge clk_sys) disable iff (!resetn) // RL18
    seq_go |-> ##[1:SEQ_MAX] seq_enabled ##0 (pins_r.txd_out && pins_r.txd_dir))
    else $error("Enable reached without pin setup");
  AST_OPEN_DRAIN_ENABLE_FIRST: assert property (@(posedge clk_sys) disable iff (!resetn) // RL19
    (state_r == S_PINDIR && onew_r) |-> cfg_r.open_drain_enable == req_r.open_drain_enable)
    else $error("Direction set before open drain choice");
  AST_IRQ_OFF: assert property (@(posedge clk_sys) disable iff (!resetn) // RL21
    (state_r != S_IDLE) |-> !dev_irq_en)
    else $error("Interrupts enabled during initialisation");
  AST_ERR_DIV: assert property (@(posedge clk_sys) disable iff (!resetn) // RL4
    (go_w && bad_div) |=> flag_r[`UCG_ST_ERRDIV] && state_r == S_IDLE)
    else $error("Bad divisor start not refused");
endmodule : ucg_host
`default_nettype wire

// file: bench/ucg_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucg_dev_model
  import ucg_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire ucg_dev_cfg_t dev_cfg,
  input  wire ucg_pins_t    dev_pins,
  input  wire logic         xck_o,
  input  wire logic         xck_oe_n,
  input  wire logic         busy_req,
  output logic              dev_active,
  output logic              xck_i
);
  // ----------------------------------------------------------------
  // Transfer clock pin of the device
  // ----------------------------------------------------------------
  logic [9:0] cnt_r;
  logic       gen_r;
  logic       pat_r;
  logic       own_clk;
  // Own divider runs only when the device masters the clock pin
  assign own_clk = dev_pins.xck_dir && (dev_cfg.tx_en || dev_cfg.rx_en) &&
                   (dev_cfg.mode inside {UCG_SYNC_MASTER, UCG_SPI_MASTER});
  // Half period is the integer divisor part; fraction ignored in sync modes
  always_ff @(posedge clk_sys) begin
    pat_r <= resetn ? ~pat_r : 1'b0;
    if (!resetn || !own_clk) begin
      cnt_r <= 10'h000;
      gen_r <= 1'b0;
    end else if (cnt_r + 10'd1 >= dev_cfg.divisor[15:6]) begin
      cnt_r <= 10'h000;
      gen_r <= ~gen_r;
    end else begin
      cnt_r <= cnt_r + 10'd1;
    end
  end
  // No pull on the pin: an undriven pin shows a changing pattern out of reset, and a steady 0 while in reset
  assign xck_i      = !xck_oe_n ? xck_o : (own_clk ? gen_r : pat_r);
  assign dev_active = busy_req;
endmodule : ucg_dev_model
`default_nettype wire

// file: bench/ucg_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ucg_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module ucg_host_tb
  import ucg_pkg::*;
;
  logic         clk_sys = 1'b0;
  logic         resetn = 1'b0;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic         busy_req = 1'b0;
  logic [3:0]   avs_address = 4'h0;
  logic [31:0]  avs_writedata = 32'h0000_0000;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  ucg_dev_cfg_t dev_cfg;
  ucg_pins_t    dev_pins;
  logic         dev_irq_en;
  logic         dev_active;
  logic         xck_i;
  logic         xck_o;
  logic         xck_oe_n;
  int           mismatches = 0;
  int           comparisons = 0;
  int           cyc = 0;
  int           t_val, t_odm, t_dir, t_div, t_mode, t_en, n;
  logic         irq_low;
  ucg_dev_cfg_t pc;
  ucg_pins_t    pp;
  logic [31:0]  rd;

  ucg_host i_dut (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev_cfg(dev_cfg),
    .dev_pins(dev_pins), .dev_irq_en(dev_irq_en), .dev_active(dev_active),
    .xck_i(xck_i), .xck_o(xck_o), .xck_oe_n(xck_oe_n));
  ucg_dev_model i_dev (.clk_sys(clk_sys), .resetn(resetn), .dev_cfg(dev_cfg),
    .dev_pins(dev_pins), .xck_o(xck_o), .xck_oe_n(xck_oe_n), .busy_req(busy_req),
    .dev_active(dev_active), .xck_i(xck_i));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // Monitor: cycle of each setup step, and the hang limit
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    pc  <= dev_cfg;
    pp  <= dev_pins;
    if (dev_irq_en === 1'b0) irq_low <= 1'b1;
    if (dev_pins.txd_out && !pp.txd_out) t_val <= cyc;
    if (dev_cfg.open_drain_enable && !pc.open_drain_enable) t_odm <= cyc;
    if (dev_pins.txd_dir && !pp.txd_dir) t_dir <= cyc;
    if (dev_cfg.divisor != pc.divisor) t_div <= cyc;
    if (dev_cfg.mode != pc.mode) t_mode <= cyc;
    if (dev_cfg.tx_en && !pc.tx_en) t_en <= cyc;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Bus and sequencing tasks
  // ----------------------------------------------------------------
  // Requests rise just after an edge and drop only after the accepting edge
  task av_wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a; avs_writedata <= d; avs_write <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : av_wr
  task av_rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a; avs_read <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : av_rd
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic inv, ph, ord, od, ow);
    ctl = 32'h0000_0601; // start, transmitter and receiver on
    ctl[`UCG_CTRL_MODE_H:`UCG_CTRL_MODE_L] = m;
    ctl[`UCG_CTRL_INV] = inv;
    ctl[`UCG_CTRL_PHASE] = ph;
    ctl[`UCG_CTRL_ORDER] = ord;
    ctl[`UCG_CTRL_OPEN_DRAIN_ENABLE] = od;
    ctl[`UCG_CTRL_ONEW] = ow;
  endfunction : ctl
  // Poll with a bounded count, then clear the sticky flags
  task wait_done();
    rd = 32'h0000_0000;
    for (int k = 0; k < 20 && rd[`UCG_ST_DONE] !== 1'b1; k++) av_rd(`UCG_OFS_STATUS, rd);
    `CHK(rd[`UCG_ST_DONE], 1'b1)
    av_wr(`UCG_OFS_STATUS, 32'h0000_001E);
  endtask : wait_done
  task meas(output int h);
    logic l;
    int   k;
    l = xck_o;
    k = 0;
    while (xck_o === l && k < 40) begin @(posedge clk_sys); k++; end
    l = xck_o;
    h = 0;
    while (xck_o === l && h < 40) begin @(posedge clk_sys); h++; end
  endtask : meas
  task do_reset();
    resetn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset
  task finish_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    `CHK(dev_cfg.divisor, 16'h0040)
    `CHK(dev_irq_en, 1'b1)
    `CHK(xck_oe_n, 1'b1)
    av_rd(`UCG_OFS_BAUD, rd);
    `CHK(rd, 32'h0000_0040)
    av_rd(`UCG_OFS_XCKDIV, rd);
    `CHK(rd, 32'h0000_0004)
    av_rd(4'h2, rd); // unmapped
    `CHK(rd, 32'h0000_0000)
    // Full-duplex setup into sync master: four cycles per step, irq held off
    irq_low = 1'b0;
    av_wr(`UCG_OFS_BAUD, 32'h0000_0100);
    av_wr(`UCG_OFS_CTRL, ctl(3'd2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wait_done();
    `CHK(t_dir - t_val, 4)
    `CHK(t_div - t_dir, 4)
    `CHK(t_mode - t_div, 4)
    `CHK(t_en - t_mode, 4)
    `CHK(irq_low, 1'b1)
    `CHK(dev_irq_en, 1'b1)
    // Refused starts: small divisor, sync fraction, device still busy
    av_wr(`UCG_OFS_BAUD, 32'h0000_003F);
    av_wr(`UCG_OFS_CTRL, ctl(3'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    av_rd(`UCG_OFS_STATUS, rd);
    `CHK(rd[`UCG_ST_ERRDIV], 1'b1)
    `CHK(rd[`UCG_ST_BUSY], 1'b0)
    av_wr(`UCG_OFS_BAUD, 32'h0000_0141);
    av_wr(`UCG_OFS_CTRL, ctl(3'd2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    av_rd(`UCG_OFS_STATUS, rd);
    `CHK(rd[`UCG_ST_ERRFRAC], 1'b1)
    busy_req <= 1'b1;
    av_wr(`UCG_OFS_BAUD, 32'h0000_0100);
    av_wr(`UCG_OFS_CTRL, ctl(3'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    av_rd(`UCG_OFS_STATUS, rd);
    `CHK(rd[`UCG_ST_ERRACT], 1'b1)
    `CHK(rd[`UCG_ST_ACTIVE], 1'b1)
    `CHK(dev_cfg.mode, UCG_SYNC_MASTER)
    av_rd(`UCG_OFS_CTRL, rd);
    `CHK(rd, 32'h0000_0600)
    busy_req <= 1'b0;
    av_wr(`UCG_OFS_STATUS, 32'h0000_001C);
    // Every mode; edge settings change only between transfers
    for (int m = 0; m < 5; m++) begin
      av_wr(`UCG_OFS_BAUD, (m < 2) ? 32'h0000_0041 : 32'h0000_0100);
      av_wr(`UCG_OFS_CTRL, ctl(m[2:0], m[0], m[1], m[0] ^ m[1], 1'b0, 1'b0));
      wait_done();
      `CHK(dev_cfg.mode, ucg_mode_t'(m))
      `CHK(dev_cfg.divisor, (m < 2) ? 16'h0041 : 16'h0100)
      `CHK(dev_cfg.double_speed_setting, 1'(m == 1))
      `CHK(dev_cfg.pin_invert_enable, 1'(m[0]))
      `CHK(dev_cfg.spi_clock_phase, 1'(m[1]))
      `CHK(dev_cfg.spi_bit_order, 1'(m[0] ^ m[1]))
      `CHK(xck_oe_n, 1'(m != 3))
    end
    // Sync slave: host makes the transfer clock, each phase long enough
    av_wr(`UCG_OFS_XCKDIV, 32'h0000_0005);
    av_wr(`UCG_OFS_CTRL, ctl(3'd3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wait_done();
    meas(n);
    `CHK(n, 5)
    av_wr(`UCG_OFS_XCKDIV, 32'h0000_0002);
    av_wr(`UCG_OFS_CTRL, ctl(3'd3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wait_done();
    meas(n);
    `CHK(n, 3)
    // One-wire setup after a second reset: open drain before direction
    do_reset();
    av_wr(`UCG_OFS_BAUD, 32'h0000_0100);
    av_wr(`UCG_OFS_CTRL, ctl(3'd0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
    wait_done();
    `CHK(t_odm - t_val, 4)
    `CHK(t_dir - t_odm, 4)
    `CHK(dev_cfg.open_drain_enable, 1'b1)
    finish_test();
  end
endmodule : ucg_host_tb
`default_nettype wire
